/* File: gplp_map.svh */
// register indices, field masks, bit positions and reset values of the i/o banks
`ifndef GPLP_MAP_SVH
`define GPLP_MAP_SVH

// bank geometry and bank slots inside the packed bank arrays
`define GPLP_BANKS 5
`define GPLP_WIDTH 8
`define GPLP_BANK_L 0
`define GPLP_BANK_M 1
`define GPLP_BANK_N 2
`define GPLP_BANK_O 3
`define GPLP_BANK_P 4

// register indices; byte address on the bus is four times the index
`define GPLP_IDX_M_LATCH 32'hFFFFF0C0
`define GPLP_IDX_L_LATCH 32'hFFFFF0C1
`define GPLP_IDX_M_DIR 32'hFFFFF0C4
`define GPLP_IDX_L_DIR 32'hFFFFF0C5
`define GPLP_IDX_L_ALT 32'hFFFFF0C9
`define GPLP_IDX_P_LATCH 32'hFFFFF0D1
`define GPLP_IDX_O_LATCH 32'hFFFFF0D2
`define GPLP_IDX_N_LATCH 32'hFFFFF0D3
`define GPLP_IDX_P_DIR 32'hFFFFF0D5
`define GPLP_IDX_O_DIR 32'hFFFFF0D6
`define GPLP_IDX_N_DIR 32'hFFFFF0D7
`define GPLP_IDX_N_ALT 32'hFFFFF0DB
`define GPLP_IDX_N_DRAIN 32'hFFFFF0DF

// reset values
`define GPLP_LATCH_RST 8'hFF
`define GPLP_CTRL_RST 8'h00
`define GPLP_OE_N_RST 8'hFF

// implemented bits of the bank n function and drain registers
`define GPLP_N_ALT_MASK 8'h07
`define GPLP_N_DRAIN_MASK 8'h05

// bank n pin positions of the serial channel
`define GPLP_N_TX_BIT 0
`define GPLP_N_RX_BIT 1
`define GPLP_N_CLK_BIT 2

// idle level handed to the serial channel when its pin is not routed
`define GPLP_SER_IDLE 1'b1

`endif

/* File: gplp_pkg.sv */
// types shared by the i/o bank block
`include "gplp_map.svh"
package gplp_pkg;

  typedef logic [`GPLP_BANKS-1:0][`GPLP_WIDTH-1:0] gplp_bank_t;

  // register selected by a bus address
  typedef enum logic [3:0] {
    REG_NONE = 4'h0,
    REG_M_LATCH = 4'h1,
    REG_L_LATCH = 4'h2,
    REG_M_DIR = 4'h3,
    REG_L_DIR = 4'h4,
    REG_L_ALT = 4'h5,
    REG_P_LATCH = 4'h6,
    REG_O_LATCH = 4'h7,
    REG_N_LATCH = 4'h8,
    REG_P_DIR = 4'h9,
    REG_O_DIR = 4'hA,
    REG_N_DIR = 4'hB,
    REG_N_ALT = 4'hC,
    REG_N_DRAIN = 4'hD
  } gplp_reg_e;

  // timer inputs fed from bank l, bit 7 down to bit 0
  typedef struct packed {
    logic wide_timer_one_in_b;
    logic wide_timer_one_in_a;
    logic wide_timer_zero_in_b;
    logic wide_timer_zero_in_a;
    logic eight_bit_timer_d_in;
    logic eight_bit_timer_c_in;
    logic eight_bit_timer_b_in;
    logic eight_bit_timer_a_in;
  } gplp_timer_s;

  // signals the serial channel drives towards the pins
  typedef struct packed {
    logic serial_transmit_line;
    logic serial_clock_out;
    logic serial_clock_oe;
  } gplp_ser_drv_s;

  // pin levels handed to the serial channel
  typedef struct packed {
    logic serial_receive_line;
    logic serial_clock_line;
    logic serial_clear_to_send;
  } gplp_ser_obs_s;

  // whole state of the block
  typedef struct packed {
    gplp_bank_t latch;
    gplp_bank_t dir;
    logic [`GPLP_WIDTH-1:0] alt_l;
    logic [`GPLP_WIDTH-1:0] alt_n;
    logic [`GPLP_WIDTH-1:0] drain;
    gplp_bank_t sync1;
    gplp_bank_t sync2;
    gplp_bank_t pin_out;
    gplp_bank_t pin_oe_n;
    gplp_timer_s timer;
    gplp_ser_obs_s ser_in;
    logic ack;
    logic [31:0] rdata;
  } gplp_state_s;

  localparam gplp_state_s GPLP_ST_RST = '{
    latch: {`GPLP_BANKS{`GPLP_LATCH_RST}},
    dir: {`GPLP_BANKS{`GPLP_CTRL_RST}},
    alt_l: `GPLP_CTRL_RST,
    alt_n: `GPLP_CTRL_RST,
    drain: `GPLP_CTRL_RST,
    sync1: '0,
    sync2: '0,
    pin_out: {`GPLP_BANKS{`GPLP_LATCH_RST}},
    pin_oe_n: {`GPLP_BANKS{`GPLP_OE_N_RST}},
    timer: '0,
    ser_in: {3{`GPLP_SER_IDLE}},
    ack: 1'b0,
    rdata: 32'h0000_0000
  };

endpackage

/* File: gplp_top.sv */
// i/o banks l, m, n, o and p with a classic wishbone register slave
// Contract
// [RL1] bank l direction: 0 input, 1 output, cleared
// [RL2] bank l function bit routes pin to timer
// [RL3] l pins 0-3 eight-bit, 4-7 wide timers
// [RL4] reset clears bank l direction and function
// [RL5] bank m direction per pin: 0 in, 1 out
// [RL6] reset clears bank m direction bits
// [RL7] data latches preset to one at reset
// [RL8] bank n direction per pin: 0 in, 1 out
// [RL9] n function bit 0 drives transmit line
// [RL10] n function bit 1 feeds receive line
// [RL11] n function bit 2 carries serial clock/cts
// [RL12] reset clears bank n direction and function
// [RL13] drain bits 2, 0 select open-drain drive
// [RL14] banks o and p have own direction registers
// [RL15] reset clears bank o and p directions
// [RL16] latch always written, drives only plain outputs
// [RL17] data read: pin if input, latch if output; bank n serial pins read the pin even while driven
`timescale 1ns/1ps
`include "gplp_map.svh"
module gplp_top (
  input wire logic CORE_CLK,
  input wire logic SYS_RST,
  input wire logic WB_CYC_I,
  input wire logic WB_STB_I,
  input wire logic WB_WE_I,
  input wire logic [31:0] WB_ADR_I,
  input wire logic [3:0] WB_SEL_I,
  input wire logic [31:0] WB_DAT_I,
  output logic [31:0] WB_DAT_O,
  output logic WB_ACK_O,
  input wire gplp_pkg::gplp_bank_t PIN_IN,
  output gplp_pkg::gplp_bank_t PIN_OUT,
  output gplp_pkg::gplp_bank_t PIN_OE_N,
  output gplp_pkg::gplp_timer_s TIMER_IN,
  input wire gplp_pkg::gplp_ser_drv_s SER_DRV,
  output gplp_pkg::gplp_ser_obs_s SER_OBS
);
  import gplp_pkg::*;

  gplp_state_s st;
  gplp_state_s next_st;

  // true when the word address hits a register index
  function automatic logic hit(input logic [31:0] adr, input logic [31:0] idx);
    hit = (adr[31:2] == idx[29:0]);
  endfunction

  // address to register decode, shared by write and read paths
  function automatic gplp_reg_e decode(input logic [31:0] adr);
    gplp_reg_e r;
    r = REG_NONE;
    if (hit(adr, `GPLP_IDX_M_LATCH)) r = REG_M_LATCH;
    if (hit(adr, `GPLP_IDX_L_LATCH)) r = REG_L_LATCH;
    if (hit(adr, `GPLP_IDX_M_DIR)) r = REG_M_DIR;
    if (hit(adr, `GPLP_IDX_L_DIR)) r = REG_L_DIR;
    if (hit(adr, `GPLP_IDX_L_ALT)) r = REG_L_ALT;
    if (hit(adr, `GPLP_IDX_P_LATCH)) r = REG_P_LATCH;
    if (hit(adr, `GPLP_IDX_O_LATCH)) r = REG_O_LATCH;
    if (hit(adr, `GPLP_IDX_N_LATCH)) r = REG_N_LATCH;
    if (hit(adr, `GPLP_IDX_P_DIR)) r = REG_P_DIR;
    if (hit(adr, `GPLP_IDX_O_DIR)) r = REG_O_DIR;
    if (hit(adr, `GPLP_IDX_N_DIR)) r = REG_N_DIR;
    if (hit(adr, `GPLP_IDX_N_ALT)) r = REG_N_ALT;
    if (hit(adr, `GPLP_IDX_N_DRAIN)) r = REG_N_DRAIN;
    decode = r;
  endfunction

  // data register read: sampled pin where not a plain output, latch where a plain output
  function automatic logic [`GPLP_WIDTH-1:0] bank_read(
    input logic [`GPLP_WIDTH-1:0] latch,
    input logic [`GPLP_WIDTH-1:0] pin,
    input logic [`GPLP_WIDTH-1:0] drv
  );
    bank_read = (latch & drv) | (pin & ~drv); // RL17
  endfunction

  gplp_reg_e sel_r;
  logic req;
  logic wr;
  logic [`GPLP_WIDTH-1:0] wdat;
  gplp_bank_t alt;
  gplp_bank_t drv;
  gplp_bank_t val;
  logic [`GPLP_WIDTH-1:0] rd;

  // bus request qualification; ack answers one cycle after the strobe
  always_comb begin
    sel_r = decode(WB_ADR_I);
    req = WB_CYC_I & WB_STB_I & ~st.ack;
    wr = req & WB_WE_I & WB_SEL_I[0];
    wdat = WB_DAT_I[`GPLP_WIDTH-1:0];
  end

  // alternate-function map per bank and the resulting plain drive enables
  always_comb begin
    alt = '0;
    alt[`GPLP_BANK_L] = st.alt_l; // RL2
    alt[`GPLP_BANK_N] = st.alt_n & `GPLP_N_ALT_MASK;
    drv = st.dir & ~alt; // RL16
    val = st.latch;
    // serial transmit line replaces the latch on bank n pin 0
    if (st.alt_n[`GPLP_N_TX_BIT]) begin
      val[`GPLP_BANK_N][`GPLP_N_TX_BIT] = SER_DRV.serial_transmit_line; // RL9
      drv[`GPLP_BANK_N][`GPLP_N_TX_BIT] = 1'b1; // RL9
    end
    // serial clock drives pin 2 only while the channel enables it
    if (st.alt_n[`GPLP_N_CLK_BIT]) begin
      val[`GPLP_BANK_N][`GPLP_N_CLK_BIT] = SER_DRV.serial_clock_out; // RL11
      drv[`GPLP_BANK_N][`GPLP_N_CLK_BIT] = SER_DRV.serial_clock_oe; // RL11
    end
  end

  // register read mux; write-only and unmapped locations read zero
  always_comb begin
    rd = '0;
    unique case (sel_r)
      REG_L_LATCH: rd = bank_read(st.latch[`GPLP_BANK_L], st.sync2[`GPLP_BANK_L],
                                  drv[`GPLP_BANK_L]);
      REG_M_LATCH: rd = bank_read(st.latch[`GPLP_BANK_M], st.sync2[`GPLP_BANK_M],
                                  drv[`GPLP_BANK_M]);
      REG_N_LATCH: rd = bank_read(st.latch[`GPLP_BANK_N], st.sync2[`GPLP_BANK_N],
                                  st.dir[`GPLP_BANK_N] & ~alt[`GPLP_BANK_N]);
      REG_O_LATCH: rd = bank_read(st.latch[`GPLP_BANK_O], st.sync2[`GPLP_BANK_O],
                                  drv[`GPLP_BANK_O]);
      REG_P_LATCH: rd = bank_read(st.latch[`GPLP_BANK_P], st.sync2[`GPLP_BANK_P],
                                  drv[`GPLP_BANK_P]);
      default: rd = '0;
    endcase
  end

  // next state: synchronisers, register writes, pin and unit outputs
  always_comb begin
    next_st = st;
    // two-stage pin synchroniser; only stage two is looked at
    next_st.sync1 = PIN_IN;
    next_st.sync2 = st.sync1;
    // bus answer
    next_st.ack = req;
    next_st.rdata = 32'h0000_0000;
    if (req & ~WB_WE_I) begin
      next_st.rdata[`GPLP_WIDTH-1:0] = rd;
    end
    // register writes; latches load whatever the direction
    if (wr) begin
      unique case (sel_r)
        REG_L_LATCH: next_st.latch[`GPLP_BANK_L] = wdat; // RL16
        REG_M_LATCH: next_st.latch[`GPLP_BANK_M] = wdat; // RL16
        REG_N_LATCH: next_st.latch[`GPLP_BANK_N] = wdat; // RL16
        REG_O_LATCH: next_st.latch[`GPLP_BANK_O] = wdat; // RL16
        REG_P_LATCH: next_st.latch[`GPLP_BANK_P] = wdat; // RL16
        REG_L_DIR: next_st.dir[`GPLP_BANK_L] = wdat; // RL1
        REG_M_DIR: next_st.dir[`GPLP_BANK_M] = wdat; // RL5
        REG_N_DIR: next_st.dir[`GPLP_BANK_N] = wdat; // RL8
        REG_O_DIR: next_st.dir[`GPLP_BANK_O] = wdat; // RL14
        REG_P_DIR: next_st.dir[`GPLP_BANK_P] = wdat; // RL14
        REG_L_ALT: next_st.alt_l = wdat; // RL2
        REG_N_ALT: next_st.alt_n = wdat & `GPLP_N_ALT_MASK;
        REG_N_DRAIN: next_st.drain = wdat & `GPLP_N_DRAIN_MASK; // RL13
        default: next_st.rdata = next_st.rdata; // unmapped: acked, no effect
      endcase
    end
    // pin drivers: oe low while driving
    next_st.pin_out = val;
    next_st.pin_oe_n = ~drv; // RL1 RL5 RL8 RL14
    // open-drain pins only pull low and float for a one
    for (int b = 0; b < `GPLP_WIDTH; b++) begin
      if (st.drain[b]) begin
        next_st.pin_out[`GPLP_BANK_N][b] = 1'b0; // RL13
        next_st.pin_oe_n[`GPLP_BANK_N][b] =
          ~(drv[`GPLP_BANK_N][b] & ~val[`GPLP_BANK_N][b]); // RL13
      end
    end
    // timer inputs: sampled bank l levels where routed, else low
    next_st.timer = gplp_timer_s'(st.sync2[`GPLP_BANK_L] & st.alt_l); // RL2 RL3
    // serial channel inputs: pin levels where routed, else idle high
    next_st.ser_in.serial_receive_line = `GPLP_SER_IDLE;
    next_st.ser_in.serial_clock_line = `GPLP_SER_IDLE;
    next_st.ser_in.serial_clear_to_send = `GPLP_SER_IDLE;
    if (st.alt_n[`GPLP_N_RX_BIT]) begin
      next_st.ser_in.serial_receive_line =
        st.sync2[`GPLP_BANK_N][`GPLP_N_RX_BIT]; // RL10
    end
    if (st.alt_n[`GPLP_N_CLK_BIT]) begin
      next_st.ser_in.serial_clock_line =
        st.sync2[`GPLP_BANK_N][`GPLP_N_CLK_BIT]; // RL11
      next_st.ser_in.serial_clear_to_send =
        st.sync2[`GPLP_BANK_N][`GPLP_N_CLK_BIT]; // RL11
    end
  end

  // state register; reset clears controls and presets latches to one
  always_ff @(posedge CORE_CLK or posedge SYS_RST) begin
    if (SYS_RST) begin
      st <= GPLP_ST_RST; // RL4 RL6 RL7 RL12 RL15
    end else begin
      st <= next_st;
    end
  end

  // outputs straight from the state register
  assign WB_DAT_O = st.rdata;
  assign WB_ACK_O = st.ack;
  assign PIN_OUT = st.pin_out;
  assign PIN_OE_N = st.pin_oe_n;
  assign TIMER_IN = st.timer;
  assign SER_OBS = st.ser_in;

endmodule // gplp_top

/* File: gplp_top_properties.sv */
// concurrent checks on the ports of the i/o bank block
`timescale 1ns/1ps
module gplp_top_properties (
  input wire logic CORE_CLK,
  input wire logic SYS_RST,
  input wire logic WB_CYC_I,
  input wire logic WB_STB_I,
  input wire logic WB_WE_I,
  input wire logic [31:0] WB_DAT_O,
  input wire logic WB_ACK_O,
  input wire gplp_pkg::gplp_bank_t PIN_IN,
  input wire gplp_pkg::gplp_bank_t PIN_OUT,
  input wire gplp_pkg::gplp_bank_t PIN_OE_N,
  input wire gplp_pkg::gplp_timer_s TIMER_IN,
  input wire gplp_pkg::gplp_ser_obs_s SER_OBS
);
  import gplp_pkg::*;
  default clocking cb @(posedge CORE_CLK); endclocking
  default disable iff (SYS_RST);
  // bus answer: one-cycle ack, only for a taken request, data zero outside it
  AST_ACK_ONE: assert property (WB_ACK_O |=> !WB_ACK_O) else $error("ack longer than one cycle");
  AST_ACK_CAUSE: assert property (WB_ACK_O |-> $past(WB_CYC_I && WB_STB_I && !WB_ACK_O))
    else $error("ack without a request");
  AST_DAT_IDLE: assert property (
    WB_DAT_O[31:8] == 24'h0 && (WB_ACK_O || WB_DAT_O == 32'h0))
    else $error("read data outside the ack cycle");
  // routed pin levels reach timers and serial unit three edges later
  AST_TIMER_PIN: assert property ((TIMER_IN & ~$past(PIN_IN[0], 3)) == 8'h00)
    else $error("timer input high while pin low");
  AST_RX_PIN: assert property (!SER_OBS.serial_receive_line |-> !$past(PIN_IN[2][1], 3))
    else $error("receive line low without pin low");
  // plain banks only change their drive after a register write
  AST_OE_BY_WRITE: assert property ($changed({PIN_OE_N[4:3], PIN_OE_N[1:0]})
    |-> $past(WB_ACK_O && WB_WE_I)) else $error("drive enable moved without a write");
  AST_OUT_BY_WRITE: assert property ($changed({PIN_OUT[4:3], PIN_OUT[1:0]})
    |-> $past(WB_ACK_O && WB_WE_I)) else $error("pin output moved without a write");
  // values held while reset is applied
  AST_RST_PINS: assert property (disable iff (1'b0)
    SYS_RST |-> PIN_OE_N == '1 && PIN_OUT == '1)
    else $error("pins not released in reset");
  AST_RST_SIDE: assert property (disable iff (1'b0)
    SYS_RST |-> TIMER_IN == 8'h00 && SER_OBS == 3'b111 && !WB_ACK_O)
    else $error("routing outputs not idle in reset");
  // main scenarios
  COV_WRITE: cover property (WB_ACK_O && WB_WE_I);
  COV_TIMER: cover property (TIMER_IN != 8'h00);
  COV_RX: cover property (!SER_OBS.serial_receive_line);
endmodule // gplp_top_properties

/* File: gplp_pads.sv */
// pad model: the device drive wins, else the outside level
`timescale 1ns/1ps
module gplp_pads (
  input wire gplp_pkg::gplp_bank_t pin_out,
  input wire gplp_pkg::gplp_bank_t pin_oe_n,
  input wire gplp_pkg::gplp_bank_t ext_lvl,
  output gplp_pkg::gplp_bank_t pin_in
);
  import gplp_pkg::*;
  // driven bits follow the device, released bits the outside devices
  assign pin_in = (pin_out & ~pin_oe_n) | (ext_lvl & pin_oe_n);
endmodule // gplp_pads

/* File: gplp_top_tb.sv */
// self-checking bench for the i/o bank block
`timescale 1ns/1ps
`include "gplp_map.svh"
module gplp_top_tb;
  import gplp_pkg::*;
  logic CORE_CLK = 1'b0;
  logic SYS_RST = 1'b0;
  logic WB_CYC_I = 1'b0;
  logic WB_STB_I = 1'b0;
  logic WB_WE_I = 1'b0;
  logic [31:0] WB_ADR_I = 32'h0;
  logic [3:0] WB_SEL_I = 4'h0;
  logic [31:0] WB_DAT_I = 32'h0;
  logic [31:0] WB_DAT_O;
  logic WB_ACK_O;
  gplp_bank_t PIN_IN;
  gplp_bank_t PIN_OUT;
  gplp_bank_t PIN_OE_N;
  gplp_timer_s TIMER_IN;
  gplp_ser_drv_s SER_DRV = 3'b100;
  gplp_ser_obs_s SER_OBS;
  int n_mismatch = 0;
  int checks_done = 0;
  int cycles = 0;
  logic [31:0] rd;
  // latch and direction indices of banks l, m, n, o, p
  logic [31:0] lat_idx [5] = '{`GPLP_IDX_L_LATCH, `GPLP_IDX_M_LATCH, `GPLP_IDX_N_LATCH,
    `GPLP_IDX_O_LATCH, `GPLP_IDX_P_LATCH};
  logic [31:0] dir_idx [5] = '{`GPLP_IDX_L_DIR, `GPLP_IDX_M_DIR, `GPLP_IDX_N_DIR,
    `GPLP_IDX_O_DIR, `GPLP_IDX_P_DIR};
  gplp_top gplp_top_inst (.CORE_CLK(CORE_CLK), .SYS_RST(SYS_RST), .WB_CYC_I(WB_CYC_I),
    .WB_STB_I(WB_STB_I), .WB_WE_I(WB_WE_I), .WB_ADR_I(WB_ADR_I), .WB_SEL_I(WB_SEL_I),
    .WB_DAT_I(WB_DAT_I), .WB_DAT_O(WB_DAT_O), .WB_ACK_O(WB_ACK_O), .PIN_IN(PIN_IN),
    .PIN_OUT(PIN_OUT), .PIN_OE_N(PIN_OE_N), .TIMER_IN(TIMER_IN), .SER_DRV(SER_DRV),
    .SER_OBS(SER_OBS));
  gplp_pads gplp_pads_inst (.pin_out(PIN_OUT), .pin_oe_n(PIN_OE_N), .ext_lvl({5{8'hC1}}),
    .pin_in(PIN_IN));
  // clock and hang guard
  always #4 CORE_CLK = ~CORE_CLK;
  always @(posedge CORE_CLK) begin
    cycles++;
    if (cycles == 5000) begin
      n_mismatch++;
      complete_run();
    end
  end
  task automatic complete_run;
    $display("mismatches %0d checks %0d", n_mismatch, checks_done);
    if (n_mismatch == 0 && checks_done > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask
  task automatic chk(input logic [39:0] got, input logic [39:0] exp);
    checks_done++;
    if (got !== exp) begin
      n_mismatch++;
      $display("mismatch at %0t got %h exp %h", $time, got, exp);
    end
  endtask
  // one classic wishbone cycle, released after the ack edge
  task automatic wb(input logic we, input logic [31:0] idx, input logic [3:0] sel,
      input logic [7:0] wd);
    WB_CYC_I <= 1'b1;
    WB_STB_I <= 1'b1;
    WB_WE_I <= we;
    WB_ADR_I <= idx << 2;
    WB_SEL_I <= sel;
    WB_DAT_I <= {24'h0, wd};
    @(posedge CORE_CLK);
    while (WB_ACK_O !== 1'b1) @(posedge CORE_CLK);
    rd = WB_DAT_O;
    WB_CYC_I <= 1'b0;
    WB_STB_I <= 1'b0;
    @(posedge CORE_CLK);
  endtask
  // test sequence
  initial begin
    SYS_RST <= 1'b1;
    repeat (4) @(posedge CORE_CLK);
    SYS_RST <= 1'b0;
    @(posedge CORE_CLK);
    chk(PIN_OE_N, {5{8'hFF}});
    chk(PIN_OUT, {5{8'hFF}});
    chk(SER_OBS, 3'b111);
    for (int b = 0; b < 5; b++) begin
      wb(1'b0, dir_idx[b], 4'h1, 8'h00);
      chk(rd, 32'h0);
      wb(1'b1, lat_idx[b], 4'h1, 8'h5A);
      chk(PIN_OE_N[b], 8'hFF);
      wb(1'b1, dir_idx[b], 4'h1, 8'h0F);
      chk(PIN_OE_N[b], 8'hF0);
      chk(PIN_OUT[b] & 8'h0F, 8'h0A);
      wb(1'b0, lat_idx[b], 4'h1, 8'h00);
      chk(rd, 32'hCA);
    end
    wb(1'b1, `GPLP_IDX_M_DIR, 4'h0, 8'hFF);
    chk(PIN_OE_N[1], 8'hF0);
    wb(1'b1, 32'hFFFFF0C8, 4'h1, 8'hFF);
    wb(1'b0, 32'hFFFFF0C8, 4'h1, 8'h00);
    chk(rd, 32'h0);
    wb(1'b1, `GPLP_IDX_L_ALT, 4'h1, 8'hFF);
    chk(PIN_OE_N[0], 8'hFF);
    repeat (3) @(posedge CORE_CLK);
    chk(TIMER_IN, 8'hC1);
    wb(1'b1, `GPLP_IDX_N_ALT, 4'h1, 8'hFF);
    SER_DRV <= 3'b000;
    repeat (3) @(posedge CORE_CLK);
    chk({PIN_OE_N[2][2:0], PIN_OUT[2][0]}, 4'b1100);
    chk(SER_OBS, 3'b000);
    SER_DRV <= 3'b011;
    repeat (2) @(posedge CORE_CLK);
    chk({PIN_OE_N[2][2], PIN_OUT[2][2]}, 2'b01);
    // the driven serial clock comes back through the pad to clock and cts
    repeat (3) @(posedge CORE_CLK);
    chk(SER_OBS, 3'b011);
    wb(1'b1, `GPLP_IDX_N_DRAIN, 4'h1, 8'hFF);
    chk({PIN_OE_N[2][2], PIN_OUT[2][2], PIN_OE_N[2][0], PIN_OUT[2][0]}, 4'b1000);
    SER_DRV <= 3'b100;
    repeat (2) @(posedge CORE_CLK);
    chk({PIN_OE_N[2][0], PIN_OUT[2][0]}, 2'b10);
    SYS_RST <= 1'b1;
    repeat (2) @(posedge CORE_CLK);
    SYS_RST <= 1'b0;
    @(posedge CORE_CLK);
    chk(PIN_OE_N, {5{8'hFF}});
    chk(PIN_OUT, {5{8'hFF}});
    chk({TIMER_IN, SER_OBS}, 11'h007);
    wb(1'b1, `GPLP_IDX_M_DIR, 4'h1, 8'hFF);
    chk(PIN_OUT[1], 8'hFF);
    // routing must stay off once the pin levels have crossed the synchroniser
    chk(PIN_OE_N, 40'hFF_FFFF_00FF);
    chk({TIMER_IN, SER_OBS}, 11'h007);
    complete_run();
  end
endmodule // gplp_top_tb
bind gplp_top gplp_top_properties gplp_top_properties_inst (.CORE_CLK(CORE_CLK),
  .SYS_RST(SYS_RST), .WB_CYC_I(WB_CYC_I), .WB_STB_I(WB_STB_I), .WB_WE_I(WB_WE_I),
  .WB_DAT_O(WB_DAT_O), .WB_ACK_O(WB_ACK_O), .PIN_IN(PIN_IN), .PIN_OUT(PIN_OUT),
  .PIN_OE_N(PIN_OE_N), .TIMER_IN(TIMER_IN), .SER_OBS(SER_OBS));
